// ==== bench/shp_port_checker.sv ====
// Checker for the pin-level carrier between the host controller and the host port
`timescale 1ns/100ps
`default_nettype none
module shp_port_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Carrier signals
	input wire logic [17:0] addr,
	input wire logic mem_reg_sel,
	input wire logic chip_sel_n,
	input wire logic read_strobe_n,
	input wire logic low_write_strobe_n,
	input wire logic high_byte_write_strobe_n,
	input wire logic bus_start_strobe,
	input wire logic rd_wr_dir,
	input wire logic host_doe,
	input wire logic dev_doe,
	input wire logic wait_pin,
	input wire logic [6:0] config_straps
);
	logic pol_reg;
	logic seen_reg;
	logic wact;
	logic strb_off;
	// ==========================================================
	// Own copy of the wait polarity, taken on the edge where the port latches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pol_reg <= 1'b0;
			seen_reg <= 1'b0;
		end else if (!seen_reg) begin
			pol_reg <= config_straps[5];
			seen_reg <= 1'b1;
		end
	end
	// Wait asserted, and no command strobe low
	assign wact = (wait_pin == pol_reg);
	assign strb_off = read_strobe_n && low_write_strobe_n;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Pin relations
	chk_tied_high: assert property (bus_start_strobe && rd_wr_dir)
		else $error("start strobe or direction not high");
	chk_no_fight: assert property (!(dev_doe && host_doe))
		else $error("both ends drive the data bus");
	chk_doe_on_read: assert property ($rose(dev_doe) |-> !chip_sel_n && !read_strobe_n)
		else $error("port drives data outside a read");
	chk_doe_release: assert property ($rose(chip_sel_n) |-> ##[0:4] !dev_doe)
		else $error("port keeps driving after deselect");
	chk_wait_held: assert property ($fell(strb_off) |-> wact [*4])
		else $error("wait not asserted at strobe start");
	chk_wait_answer: assert property ($fell(strb_off) |-> ##[4:80] !wact)
		else $error("wait never released");
	chk_three_ready: assert property ($rose(strb_off) |-> !$past(wact, 2) && !$past(wact, 3) && !$past(wact, 4))
		else $error("strobe ended without three ready samples");
	chk_setup_gap: assert property ($fell(chip_sel_n) |-> strb_off [*3])
		else $error("strobe too soon after select");
	chk_cs_hold: assert property ($rose(strb_off) |-> !chip_sel_n ##1 !chip_sel_n ##[1:2] chip_sel_n)
		else $error("select hold after strobe wrong");
	chk_addr_steady: assert property (!chip_sel_n && $past(!chip_sel_n) |-> $stable(addr) && $stable(mem_reg_sel))
		else $error("address moved during access");
	chk_hb_idle: assert property (chip_sel_n |-> high_byte_write_strobe_n && !host_doe)
		else $error("byte lane or host drive without select");
endmodule
`default_nettype wire

// ==== bench/test_strap_config_host_port.sv ====
// Self-checking bench joining the host controller and the host port
`timescale 1ns/100ps
`default_nettype none
module test_strap_config_host_port;
	import shp_pkg::*;
	typedef struct packed {logic w; logic b; logic [31:0] a; logic [15:0] d; logic [15:0] e;} shp_row_s;
	logic pclk, presetn, dev_rstn, psel, penable, pwrite, pready, pslverr, refresh_req, mode_ok, bus_tick, e, t0;
	logic [31:0] paddr, pwdata, prdata, r, st;
	logic [6:0] straps_latched;
	int failures = 0;
	int n_checks = 0;
	int cs_falls = 0;
	int n;
	logic big = 1'b0;
	// Writes first, then reads of both blocks, an alias and byte lanes
	shp_row_s rows [8] = '{
		'{1'b1, 1'b0, 32'h4000_0010, 16'h1234, 16'h0000},
		'{1'b1, 1'b0, 32'h4004_0010, 16'habcd, 16'h0000},
		'{1'b0, 1'b0, 32'h4000_0010, 16'h0000, 16'h1234},
		'{1'b0, 1'b0, 32'h4004_0010, 16'h0000, 16'habcd},
		'{1'b0, 1'b0, 32'h4100_0010, 16'h0000, 16'h1234},
		'{1'b1, 1'b1, 32'h4000_0011, 16'h0077, 16'h0000},
		'{1'b1, 1'b1, 32'h4000_0010, 16'h0055, 16'h0000},
		'{1'b0, 1'b0, 32'h4000_0010, 16'h0000, 16'h7755}};
	// ==========================================================
	// Design, carrier and checker
	shp_if shp_if_i();
	shp_host #(.CORE_MHZ10(2065), .QUARTER_CLK(1'b0), .FULL_DECODE(1'b0)) shp_host_i (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(shp_if_i));
	// Separate port reset lets the bench re-latch straps mid-run
	shp_dev #(.STORE_AW(8)) shp_dev_i (.pclk(pclk), .presetn(dev_rstn), .bus(shp_if_i), .refresh_req(refresh_req),
		.mode_ok(mode_ok), .straps_latched(straps_latched), .bus_tick(bus_tick));
	shp_port_checker shp_port_checker_i (.pclk(pclk), .presetn(dev_rstn), .addr(shp_if_i.addr),
		.mem_reg_sel(shp_if_i.mem_reg_sel), .chip_sel_n(shp_if_i.chip_sel_n), .read_strobe_n(shp_if_i.read_strobe_n),
		.low_write_strobe_n(shp_if_i.low_write_strobe_n), .high_byte_write_strobe_n(shp_if_i.high_byte_write_strobe_n),
		.bus_start_strobe(shp_if_i.bus_start_strobe), .rd_wr_dir(shp_if_i.rd_wr_dir), .host_doe(shp_if_i.host_doe),
		.dev_doe(shp_if_i.dev_doe), .wait_pin(shp_if_i.wait_pin), .config_straps(shp_if_i.config_straps));
	// ==========================================================
	// Clock, select counter and tasks
	always #2.5 pclk = ~pclk;
	always @(negedge shp_if_i.chip_sel_n) cs_falls++;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h000000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Full bus access: load, start, poll busy, fetch data, clear flags
	task automatic xfer(input logic w, input logic b, input logic [31:0] a, input logic [15:0] d,
		output logic [31:0] rd);
		logic er;
		logic [31:0] x;
		int i;
		apb(1'b1, REG_ADDR, a, x, er);
		apb(1'b1, REG_WDATA, {16'h0000, d}, x, er);
		apb(1'b1, REG_CTRL, {24'h0, big, 4'h0, b, w, 1'b1}, x, er);
		i = 0;
		st = 32'h1;
		while (st[ST_BUSY] !== 1'b0 && i < 500) begin
			apb(1'b0, REG_STATUS, 32'h0, st, er);
			i++;
		end
		apb(1'b0, REG_RDATA, 32'h0, rd, er);
		apb(1'b1, REG_STATUS, 32'h6, x, er);
	endtask
	// Watchdog far beyond the expected several hundred cycles
	initial begin
		repeat (40000) @(posedge pclk);
		failures++;
		final_report;
	end
	// ==========================================================
	// Main sequence
	initial begin
		{pclk, presetn, dev_rstn, psel, penable, pwrite, refresh_req} = 7'h00;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		dev_rstn <= 1'b1;
		repeat (2) @(posedge pclk);
		check(mode_ok, 32'h1);
		check(straps_latched, STRAP_RST | 7'h40);
		check(shp_if_i.wait_pin, 32'h0);
		t0 = bus_tick;
		@(posedge pclk);
		check(bus_tick ^ t0, 32'h1);
		apb(1'b0, REG_CSCFG, 32'h0, r, e);
		check(r, {16'h0000, 3'h0, 5'h00, 5'h04, 1'b1, MEMTYPE_VLIO});
		apb(1'b0, REG_CTRL, 32'h0, r, e);
		check(r, 32'h0);
		apb(1'b0, 8'h20, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		check(r, 32'h0);
		// Ordinary accesses from the table
		foreach (rows[k]) begin
			xfer(rows[k].w, rows[k].b, rows[k].a, rows[k].d, r);
			check(st, 32'h2);
			if (!rows[k].w) check(r, {16'h0000, rows[k].e});
		end
		// Outside the window: error flag and no select motion
		n = cs_falls;
		xfer(1'b0, 1'b0, 32'h2000_0000, 16'h0000, r);
		check(st, 32'h4);
		check(cs_falls - n, 32'h0);
		// Refresh contention stretches the access
		fork
			begin
				refresh_req <= 1'b1;
				repeat (30) @(posedge pclk);
				refresh_req <= 1'b0;
			end
		join_none
		xfer(1'b0, 1'b0, 32'h4004_0010, 16'h0000, r);
		check(r, 32'habcd);
		// Strap pins change after reset: latched copy must not follow
		apb(1'b1, REG_STRAP, 32'h6c, r, e);
		apb(1'b0, REG_STRAP, 32'h0, r, e);
		check(r, 32'h6c);
		check(straps_latched, 32'h4c);
		// Re-latch with active-high wait and run a write and a read through it
		dev_rstn <= 1'b0;
		repeat (3) @(posedge pclk);
		dev_rstn <= 1'b1;
		repeat (2) @(posedge pclk);
		check(straps_latched, 32'h6c);
		check(shp_if_i.wait_pin, 32'h1);
		xfer(1'b1, 1'b0, 32'h4004_0020, 16'h5a5a, r);
		xfer(1'b0, 1'b0, 32'h4004_0020, 16'h0000, r);
		check(r, 32'h5a5a);
		// Big-endian host order swaps the halfword bytes of a read
		big = 1'b1;
		xfer(1'b0, 1'b0, 32'h4000_0010, 16'h0000, r);
		check(r, 32'h5577);
		final_report;
	end
endmodule
`default_nettype wire

// ==== common/shp_if.sv ====
// Pin-level carrier between the host controller and the host port
`timescale 1ns/100ps
`default_nettype none
interface shp_if;
	logic [17:0] addr;
	logic mem_reg_sel;
	logic chip_sel_n;
	logic read_strobe_n;
	logic low_write_strobe_n;
	logic high_byte_write_strobe_n;
	logic bus_start_strobe;
	logic rd_wr_dir;
	logic [15:0] host_dout;
	logic host_doe;
	logic [15:0] dev_dout;
	logic dev_doe;
	logic [15:0] data;
	logic wait_pin;
	logic [6:0] config_straps;

	// Resolved data bus, floating lines read as pulled high
	assign data = dev_doe ? dev_dout : (host_doe ? host_dout : 16'hffff);

	modport host(output addr, mem_reg_sel, chip_sel_n, read_strobe_n, low_write_strobe_n,
		high_byte_write_strobe_n, bus_start_strobe, rd_wr_dir, host_dout, host_doe, config_straps,
		input data, wait_pin);
	modport dev(input addr, mem_reg_sel, chip_sel_n, read_strobe_n, low_write_strobe_n,
		high_byte_write_strobe_n, bus_start_strobe, rd_wr_dir, data, config_straps,
		output dev_dout, dev_doe, wait_pin);
endinterface
`default_nettype wire

// ==== common/shp_pkg.sv ====
// Shared constants for the strap-configured host port and its host-side controller
`default_nettype none
package shp_pkg;
	// ==========================================================
	// Straps
	localparam int STRAP_W = 7;
	localparam int STRAP_CLKDIV = 6;
	localparam int STRAP_WAITPOL = 5;
	localparam int STRAP_ENDIAN = 4;
	localparam int STRAP_RSVD = 3;
	localparam logic [3:0] MODE_GENERIC_LE = 4'h4;
	localparam logic [6:0] STRAP_RST = 7'h0c;
	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int SEL_BIT = 18;
	localparam int WINDOW_LSB = 27;
	localparam logic [4:0] WINDOW_BASE = 5'h08;
	// ==========================================================
	// Timing, device in bus ticks, host in half memory cycles
	localparam logic [3:0] DEV_ACCESS_TICKS = 4'h2;
	localparam logic [6:0] SETUP_HALVES = 7'h04;
	localparam logic [6:0] CS_HOLD_HALVES = 7'h02;
	localparam logic [1:0] READY_SAMPLES = 2'h3;
	// ==========================================================
	// Latency and clock-divide thresholds in tenths of a MHz
	localparam int LAT1_MAX = 859;
	localparam int LAT2_MAX = 1432;
	localparam int LAT3_MAX = 2005;
	localparam int DIV_NEEDED_ABOVE = 1000;
	// ==========================================================
	// APB register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_STRAP = 8'h14;
	localparam logic [7:0] REG_CSCFG = 8'h18;
	// ==========================================================
	// Register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_WRITE = 1;
	localparam int CTRL_BYTE = 2;
	localparam int CTRL_BIGEND = 7;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;
	localparam int CS_TYPE_LSB = 0;
	localparam int CS_WIDTH_BIT = 2;
	localparam int CS_LAT_LSB = 3;
	localparam int CS_PRE_LSB = 8;
	localparam int CS_REC_LSB = 13;
	localparam logic [1:0] MEMTYPE_VLIO = 2'h1;
endpackage
`default_nettype wire

// ==== hdl/shp_dev.sv ====
// Device end: strap-configured 16-bit host port with register and buffer blocks
`timescale 1ns/100ps
`default_nettype none
module shp_dev import shp_pkg::*; #(
	parameter int STORE_AW = 17
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Host bus pins
	shp_if.dev bus,
	// Core side
	input wire logic refresh_req,
	output logic mode_ok,
	output logic [STRAP_W-1:0] straps_latched,
	output logic bus_tick
);
	typedef enum logic [1:0] {D_IDLE, D_ACCESS, D_DONE} shp_dstate_e;
	typedef struct packed {
		shp_dstate_e state;
		logic captured;
		logic [STRAP_W-1:0] straps;
		logic mode_ok;
		logic phase;
		logic tick;
		logic [3:0] cnt;
		logic [15:0] rdata;
		logic doe;
		logic wait_pin;
	} shp_dev_s;
	shp_dev_s r_reg;
	shp_dev_s r_next;

	logic [15:0] regs_mem [0:(2**STORE_AW)-1];
	logic [15:0] vram_mem [0:(2**STORE_AW)-1];
	logic [3:0] pins_s;
	logic cs_n_s, rd_n_s, wr_n_s, hb_n_s;
	logic [STORE_AW-1:0] idx;
	logic [15:0] rd_word;
	logic mem_we, lo_en, hi_en, tick, pol;

	// ==========================================================
	// Strobes arrive asynchronously to pclk
	shp_sync #(.W(4), .RST_VAL(4'hf)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({bus.chip_sel_n, bus.read_strobe_n, bus.low_write_strobe_n, bus.high_byte_write_strobe_n}),
		.q(pins_s)
	);
	assign {cs_n_s, rd_n_s, wr_n_s, hb_n_s} = pins_s;

	// Only local address and select are decoded, so both blocks alias upward
	assign idx = bus.addr[STORE_AW:1];
	assign rd_word = bus.mem_reg_sel ? vram_mem[idx] : regs_mem[idx];
	// Word when A0 low and high enable low, odd address means high byte
	assign lo_en = !bus.addr[0];
	assign hi_en = !hb_n_s || bus.addr[0];

	// ==========================================================
	// Next state
	always_comb begin
		r_next = r_reg;
		mem_we = 1'b0;
		// Straps caught once, on the first edge after reset release
		if (!r_reg.captured) begin
			r_next.captured = 1'b1;
			r_next.straps = bus.config_straps;
			r_next.mode_ok = ({bus.config_straps[STRAP_ENDIAN], bus.config_straps[2:0]} == MODE_GENERIC_LE)
				&& bus.config_straps[STRAP_RSVD];
		end
		// Later strap changes never reach the latched copy
		// Polarity follows the copy being latched, so wait is right from the capture edge on
		pol = r_next.straps[STRAP_WAITPOL];
		// Divide by two makes every other pclk a bus tick
		tick = !r_reg.straps[STRAP_CLKDIV] || r_reg.phase;
		r_next.phase = r_reg.straps[STRAP_CLKDIV] ? !r_reg.phase : 1'b1;
		r_next.tick = r_next.straps[STRAP_CLKDIV] ? r_next.phase : 1'b1;
		unique case (r_reg.state)
			D_IDLE: begin
				if (r_reg.mode_ok && !cs_n_s && (!rd_n_s || !wr_n_s)) begin
					r_next.state = D_ACCESS;
					r_next.cnt = DEV_ACCESS_TICKS;
				end
			end
			D_ACCESS: begin
				// Display refresh owns the storage, so the host keeps waiting
				if (!refresh_req && tick) begin
					if (r_reg.cnt <= 4'h1) begin
						r_next.state = D_DONE;
						r_next.rdata = rd_word;
						mem_we = !wr_n_s;
					end else begin
						r_next.cnt = r_reg.cnt - 4'h1;
					end
				end
			end
			D_DONE: begin
				if (cs_n_s || (rd_n_s && wr_n_s)) begin
					r_next.state = D_IDLE;
				end
			end
			default: begin
				r_next.state = D_IDLE;
			end
		endcase
		// Wait stays asserted everywhere except after the data phase completed
		r_next.wait_pin = pol ? (r_next.state != D_DONE) : (r_next.state == D_DONE);
		// Drive data only during an enabled read
		r_next.doe = r_reg.mode_ok && !cs_n_s && !rd_n_s;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '{state: D_IDLE, captured: 1'b0, straps: STRAP_RST, mode_ok: 1'b0, phase: 1'b0,
				tick: 1'b0, cnt: 4'h0, rdata: 16'h0000, doe: 1'b0, wait_pin: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// Storage, byte lanes steered by the enables
	always_ff @(posedge pclk) begin
		if (mem_we && lo_en) begin
			if (bus.mem_reg_sel) begin
				vram_mem[idx][7:0] <= bus.data[7:0];
			end else begin
				regs_mem[idx][7:0] <= bus.data[7:0];
			end
		end
		if (mem_we && hi_en) begin
			if (bus.mem_reg_sel) begin
				vram_mem[idx][15:8] <= bus.data[15:8];
			end else begin
				regs_mem[idx][15:8] <= bus.data[15:8];
			end
		end
	end

	// Outputs
	assign bus.dev_dout = r_reg.rdata;
	assign bus.dev_doe = r_reg.doe;
	assign bus.wait_pin = r_reg.wait_pin;
	assign mode_ok = r_reg.mode_ok;
	assign straps_latched = r_reg.straps;
	assign bus_tick = r_reg.tick;
endmodule
`default_nettype wire

// ==== hdl/shp_host.sv ====
// Host end: APB-controlled variable-latency static bus master toward the host port
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Device latches all seven straps at reset release
// - Pattern 0100 selects generic little-endian bus
// - Reserved strap held at one
// - Wait polarity follows its latched strap
// - Clock strap selects divide by two
// - Bus clock kept within port maximum
// - Fast core forces divided clock strap
// - Select low registers, high display buffer
// - System address bit eighteen drives select
// - Blocks alias unless host decodes fully
// - Start strobe and direction tied high
// - Memory type field reset to 01
// - Bus width bit reset to one
// - Latency field chosen from core frequency
// - Strobe precharge field reset to zero
// - Chip-select recovery field reset to zero
// - Control bit seven clear means little-endian
// - Access extended until wait is released
// - High enable with A0 steers byte lanes
// - Three ready samples, data latched after
module shp_host import shp_pkg::*; #(
	parameter int CORE_MHZ10 = 2065,
	parameter bit QUARTER_CLK = 1'b0,
	parameter bit FULL_DECODE = 1'b0
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device pins
	shp_if.host bus
);
	// Latency field from the fastest core rate the board runs at
	function automatic logic [4:0] shp_lat(input int mhz10);
		if (mhz10 <= LAT1_MAX) begin
			return 5'h01;
		end else if (mhz10 <= LAT2_MAX) begin
			return 5'h02;
		end else if (mhz10 <= LAT3_MAX) begin
			return 5'h03;
		end
		return 5'h04;
	endfunction

	// Without a quartered memory clock a fast core must halve the port clock
	localparam logic FORCE_DIV = (CORE_MHZ10 > DIV_NEEDED_ABOVE) && !QUARTER_CLK;
	localparam logic [6:0] STRAP_INIT = STRAP_RST | {FORCE_DIV, 6'h00};
	localparam logic [15:0] CSCFG_INIT = {3'h0, 5'h00, shp_lat(CORE_MHZ10), 1'b1, MEMTYPE_VLIO};

	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_SAMPLE, H_LATCH, H_HOLD, H_GAP} shp_hstate_e;
	typedef struct packed {
		shp_hstate_e state;
		logic [6:0] cnt;
		logic [1:0] okc;
		logic wr_op;
		logic byte_op;
		logic big;
		logic [31:0] sys_addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic busy;
		logic done;
		logic err;
		logic [6:0] strap;
		logic [15:0] cscfg;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic hb_n;
		logic doe;
		logic [15:0] dout;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} shp_host_s;
	shp_host_s r_reg;
	shp_host_s r_next;

	logic ready, setup, wr, win_ok;
	logic [4:0] lat;

	// ==========================================================
	// Next state
	always_comb begin
		r_next = r_reg;
		lat = r_reg.cscfg[CS_LAT_LSB +: 5];
		// Wait asserted when the pin sits at the strapped active level
		ready = (bus.wait_pin != r_reg.strap[STRAP_WAITPOL]);
		setup = psel && !penable;
		wr = psel && penable && r_reg.pready && pwrite;
		win_ok = (r_reg.sys_addr[31:WINDOW_LSB] == WINDOW_BASE)
			&& (!FULL_DECODE || (r_reg.sys_addr[WINDOW_LSB-1:SEL_BIT+1] == 8'h00));

		// APB: read data captured in setup, answer one cycle later
		r_next.pready = setup;
		if (setup) begin
			r_next.pslverr = 1'b0;
			unique case (paddr[7:0])
				REG_CTRL: r_next.prdata = {24'h0, r_reg.big, 4'h0, r_reg.byte_op, r_reg.wr_op, 1'b0};
				REG_ADDR: r_next.prdata = r_reg.sys_addr;
				REG_WDATA: r_next.prdata = {16'h0, r_reg.wdata};
				REG_RDATA: r_next.prdata = {16'h0, r_reg.rdata};
				REG_STATUS: r_next.prdata = {29'h0, r_reg.err, r_reg.done, r_reg.busy};
				REG_STRAP: r_next.prdata = {25'h0, r_reg.strap};
				REG_CSCFG: r_next.prdata = {16'h0, r_reg.cscfg};
				default: begin
					r_next.prdata = 32'h0000_0000;
					r_next.pslverr = 1'b1;
				end
			endcase
		end
		// Order writes are locked while an access is in flight
		if (wr && !r_reg.busy) begin
			unique case (paddr[7:0])
				REG_CTRL: begin
					r_next.wr_op = pwdata[CTRL_WRITE];
					r_next.byte_op = pwdata[CTRL_BYTE];
					r_next.big = pwdata[CTRL_BIGEND];
					r_next.busy = pwdata[CTRL_START];
				end
				REG_ADDR: r_next.sys_addr = pwdata;
				REG_WDATA: r_next.wdata = pwdata[15:0];
				// Reserved strap cannot be written to anything but one
				REG_STRAP: r_next.strap = pwdata[6:0] | {FORCE_DIV, 2'h0, 1'b1, 3'h0};
				REG_CSCFG: r_next.cscfg = pwdata[15:0];
				default: begin
				end
			endcase
		end
		// Sticky flags cleared by writing one; a same-cycle set below wins
		if (wr && (paddr[7:0] == REG_STATUS)) begin
			r_next.done = r_reg.done && !pwdata[ST_DONE];
			r_next.err = r_reg.err && !pwdata[ST_ERR];
		end

		// ==========================================================
		// Bus master, one pclk per half memory cycle
		unique case (r_reg.state)
			H_IDLE: begin
				if (r_reg.busy) begin
					if (win_ok) begin
						r_next.state = H_SETUP;
						r_next.cnt = SETUP_HALVES - 7'h01;
						r_next.cs_n = 1'b0;
						r_next.hb_n = !(!r_reg.byte_op || r_reg.sys_addr[0]);
						r_next.doe = r_reg.wr_op;
						if (r_reg.byte_op) begin
							r_next.dout = {r_reg.wdata[7:0], r_reg.wdata[7:0]};
						end else begin
							r_next.dout = r_reg.big ? {r_reg.wdata[7:0], r_reg.wdata[15:8]} : r_reg.wdata;
						end
					end else begin
						r_next.busy = 1'b0;
						r_next.err = 1'b1;
					end
				end
			end
			H_SETUP: begin
				if (r_reg.cnt == 7'h00) begin
					r_next.state = H_STROBE;
					r_next.cnt = 7'({lat, 1'b0});
					r_next.rd_n = r_reg.wr_op;
					r_next.wr_n = !r_reg.wr_op;
				end else begin
					r_next.cnt = r_reg.cnt - 7'h01;
				end
			end
			H_STROBE: begin
				if (r_reg.cnt == 7'h00) begin
					r_next.state = H_SAMPLE;
					r_next.okc = 2'h0;
				end else begin
					r_next.cnt = r_reg.cnt - 7'h01;
				end
			end
			H_SAMPLE: begin
				// Only variable-latency mode honours wait
				if (r_reg.cscfg[CS_TYPE_LSB +: 2] != MEMTYPE_VLIO) begin
					r_next.state = H_LATCH;
				end else if (ready && (r_reg.okc == READY_SAMPLES - 2'h1)) begin
					r_next.state = H_LATCH;
				end else begin
					r_next.okc = ready ? r_reg.okc + 2'h1 : 2'h0;
				end
			end
			H_LATCH: begin
				// Data taken half a cycle after the third good sample
				if (!r_reg.wr_op) begin
					r_next.rdata = r_reg.big ? {bus.data[7:0], bus.data[15:8]} : bus.data;
				end
				r_next.state = H_HOLD;
				r_next.rd_n = 1'b1;
				r_next.wr_n = 1'b1;
				r_next.cnt = CS_HOLD_HALVES + 7'({r_reg.cscfg[CS_REC_LSB +: 3], 1'b0}) - 7'h01;
			end
			H_HOLD: begin
				if (r_reg.cnt == 7'h00) begin
					r_next.state = H_GAP;
					r_next.cs_n = 1'b1;
					r_next.hb_n = 1'b1;
					r_next.doe = 1'b0;
					r_next.cnt = 7'({r_reg.cscfg[CS_PRE_LSB +: 5], 1'b1});
				end else begin
					r_next.cnt = r_reg.cnt - 7'h01;
				end
			end
			H_GAP: begin
				if (r_reg.cnt == 7'h00) begin
					r_next.state = H_IDLE;
					r_next.busy = 1'b0;
					r_next.done = 1'b1;
				end else begin
					r_next.cnt = r_reg.cnt - 7'h01;
				end
			end
			default: begin
				r_next.state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '{state: H_IDLE, cnt: 7'h00, okc: 2'h0, wr_op: 1'b0, byte_op: 1'b0, big: 1'b0,
				sys_addr: 32'h0000_0000, wdata: 16'h0000, rdata: 16'h0000, busy: 1'b0, done: 1'b0,
				err: 1'b0, strap: STRAP_INIT, cscfg: CSCFG_INIT, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
				hb_n: 1'b1, doe: 1'b0, dout: 16'h0000, pready: 1'b0, prdata: 32'h0000_0000,
				pslverr: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// Outputs
	assign bus.addr = r_reg.sys_addr[ADDR_W-1:0];
	assign bus.mem_reg_sel = r_reg.sys_addr[SEL_BIT];
	assign bus.chip_sel_n = r_reg.cs_n;
	assign bus.read_strobe_n = r_reg.rd_n;
	assign bus.low_write_strobe_n = r_reg.wr_n;
	assign bus.high_byte_write_strobe_n = r_reg.hb_n;
	// Unused in this bus mode, held high from the reset strap register
	assign bus.bus_start_strobe = r_reg.strap[STRAP_RSVD];
	assign bus.rd_wr_dir = r_reg.strap[STRAP_RSVD];
	assign bus.host_dout = r_reg.dout;
	assign bus.host_doe = r_reg.doe;
	assign bus.config_straps = r_reg.strap;
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
endmodule
`default_nettype wire

// ==== hdl/shp_sync.sv ====
// Two-stage synchroniser for asynchronous strobe pins
`timescale 1ns/100ps
`default_nettype none
module shp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} shp_sync_s;
	shp_sync_s r_reg;
	shp_sync_s r_next;

	// First stage is read only by the second
	always_comb begin
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= {RST_VAL, RST_VAL};
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.s2;
endmodule
`default_nettype wire
